// [inc/flash_ctrl_pkg.sv]
// constants, encodings and carrier types for the dual-port flash read controller
// assumes a single 250 MHz clock and a flash macro with two synchronous read ports
package flash_ctrl_pkg;
  localparam int CLK_MHZ = 250;
  // register byte offsets on the register port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FUSE = 8'h0C;
  // field positions
  localparam int CTRL_WS_BIT = 0;
  localparam int ST_READY = 0;
  localparam int ST_LOCKE = 2;
  localparam int ST_PROGRAMMING_ERROR_FLAG = 3;
  localparam int ST_SECURE = 4;
  localparam int ST_PAGE_AND_CHECK_RESULT = 5;
  localparam int ST_FAST = 6;
  localparam int ST_LOCK_LSB = 16;
  localparam int CMD_CODE_W = 6;
  localparam int CMD_PAGE_LSB = 8;
  localparam int CMD_KEY_LSB = 24;
  // memory geometry: word address bit 21 selects the extra user page
  localparam int WADDR_W = 22;
  localparam int USER_BIT = 21;
  localparam int WORD_IDX_W = 7;
  localparam int PAGE_BITS = 14;
  localparam int REGION_BITS = 4;
  localparam int REGIONS = 16;
  // command numbers
  localparam logic [5:0] CMD_WRITE_PAGE = 6'h01;
  localparam logic [5:0] CMD_ERASE_PAGE = 6'h02;
  localparam logic [5:0] CMD_CLEAR_PBUF = 6'h03;
  localparam logic [5:0] CMD_LOCK = 6'h04;
  localparam logic [5:0] CMD_UNLOCK = 6'h05;
  localparam logic [5:0] CMD_ERASE_ALL = 6'h06;
  localparam logic [5:0] CMD_WRITE_FUSE = 6'h07;
  localparam logic [5:0] CMD_ERASE_FUSE = 6'h08;
  localparam logic [5:0] CMD_SET_SECURE = 6'h09;
  localparam logic [5:0] CMD_PAGE_AND = 6'h0C;
  localparam logic [5:0] CMD_WRITE_USER = 6'h0D;
  localparam logic [5:0] CMD_ERASE_USER = 6'h0E;
  localparam logic [5:0] CMD_FAST_ON = 6'h10;
  localparam logic [5:0] CMD_FAST_OFF = 6'h11;
  // settle time after a read speed change
  localparam int HS_SETTLE_NS = 40;
  localparam int HS_SETTLE_CYC = (HS_SETTLE_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_ACCESS = 8'b0000_0010,
    ST_WAIT = 8'b0000_0100,
    ST_CAPTURE = 8'b0000_1000,
    ST_CMD_RUN = 8'b0001_0000,
    ST_VOL_ERASE = 8'b0010_0000,
    ST_SETTLE = 8'b0100_0000,
    ST_QISSUE = 8'b1000_0000
  } state_e;
  typedef struct packed {
    logic en;
    logic [WADDR_W-1:0] addr;
  } rd_port_s;
  typedef struct packed {
    logic valid;
    logic [CMD_CODE_W-1:0] code;
    logic [PAGE_BITS-1:0] page;
  } flash_op_s;
endpackage : flash_ctrl_pkg

// [verilog/flash_ctrl.sv]
// flash controller: fast read port, register port, command sequencer
// assumes the flash macro returns read data one cycle after enable in zero
// wait mode and two cycles after in one wait mode, held until the next enable
// Behaviour
// R1: zero wait mode enables one read port
// R2: one wait mode reads addressed and next word
// R3: even words port zero, odd words port one
// R4: prefetched sequential word answers without wait
// R5: wait select bit chooses zero or one
// R6: sixteen lock bits guard equal page regions
// R7: fast port reads flash, writes page buffer
// R8: register port takes commands, returns status
// R9: word space two-to-twenty-one, top undefined
// R10: user page fixed at word two-to-twenty-one
// R11: erase all spares user page
// R12: user page reads like main array
// R13: speed commands stall reads until settled
// R14: fast read mode off after reset
// R15: page and check ANDs whole page
// R16: erase all: volatile, flash, then security
// R17: fuse bits and security bit readable, writable
// R18: power down flash while sleeping
// R19: clock manager keeps bus clocks running
// R20: command clears ready, completion sets it
// R21: wrong key or command flags error
// R22: command while busy flags error
// R23: command starts when fast port idle
// R24: non-sequential one wait read takes wait
`timescale 1ns/1ps
module flash_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int FUSE_N = 32,
  parameter logic [7:0] CMD_KEY = 8'hA5 // arbitrary key value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port (apb slave)
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fast read port
  input wire logic hvalid,
  input wire logic hwrite,
  input wire logic [23:0] haddr,
  input wire logic [31:0] hwdata,
  output logic hready,
  output logic [31:0] hrdata,
  // flash macro read ports
  output flash_ctrl_pkg::rd_port_s [1:0] rdPort,
  input wire logic [1:0][31:0] rdData,
  // page buffer and program/erase operations
  output logic pbufWe,
  output logic [flash_ctrl_pkg::WORD_IDX_W-1:0] pbufIdx,
  output logic [31:0] pbufData,
  output flash_ctrl_pkg::flash_op_s flashOp,
  input wire logic flashDone,
  output logic fastReadMode,
  // volatile memory erase handshake
  output logic volEraseReq,
  input wire logic volEraseAck,
  // power manager
  input wire logic sleepReq,
  output logic flashPowerDown
);
  import flash_ctrl_pkg::*;

  localparam int FUSE_IDX_W = $clog2(FUSE_N);

  state_e state;
  logic waitSel;
  logic readyFlag, progError, lockError, secure, qprResult;
  logic [REGIONS-1:0] lockBits;
  logic [FUSE_N-1:0] fuses;
  logic cmdPending;
  logic [CMD_CODE_W-1:0] cmdCode;
  logic [PAGE_BITS-1:0] cmdPage;
  logic [WADDR_W-1:0] curAddr, prefAddr;
  logic [31:0] prefData;
  logic prefValid;
  logic [7:0] settleCnt;
  logic [WORD_IDX_W-1:0] qIdx;
  logic qMode, qAcc;
  logic finish, finLockErr;
  logic [31:0] readMux;

  // region index of a page is its four top bits
  function automatic logic [REGION_BITS-1:0] regionOf(input logic [PAGE_BITS-1:0] pg);
    return pg[PAGE_BITS-1 -: REGION_BITS];
  endfunction : regionOf

  function automatic logic cmdKnown(input logic [CMD_CODE_W-1:0] c);
    case (c)
      CMD_WRITE_PAGE, CMD_ERASE_PAGE, CMD_CLEAR_PBUF, CMD_LOCK, CMD_UNLOCK,
      CMD_ERASE_ALL, CMD_WRITE_FUSE, CMD_ERASE_FUSE, CMD_SET_SECURE,
      CMD_PAGE_AND, CMD_WRITE_USER, CMD_ERASE_USER, CMD_FAST_ON,
      CMD_FAST_OFF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : cmdKnown

  // register port decode; write and read side effects act on the pready edge
  logic apbFire, apbMapped, cmdWr, statusRd, cmdOk;
  assign apbFire = psel & penable & pready;
  assign apbMapped = (paddr == REG_CTRL) | (paddr == REG_CMD) |
                     (paddr == REG_STATUS) | (paddr == REG_FUSE);
  assign cmdWr = apbFire & pwrite & (paddr == REG_CMD); // R8
  assign statusRd = apbFire & ~pwrite & (paddr == REG_STATUS);
  assign cmdOk = readyFlag & (pwdata[CMD_KEY_LSB +: 8] == CMD_KEY) &
                 cmdKnown(pwdata[CMD_CODE_W-1:0]); // R21 R22

  // fast port request decode
  logic [WADDR_W-1:0] wAddr, nextAddr;
  logic busReq, prefHit, cmdStart, lockHit;
  assign wAddr = haddr[23:2]; // R9 R10 R12
  assign nextAddr = wAddr + 22'h00_0001;
  assign busReq = hvalid & ~hready;
  assign prefHit = waitSel & prefValid & (wAddr == prefAddr); // R24
  assign cmdStart = (state == ST_IDLE) & ~busReq & cmdPending; // R23
  assign lockHit = (((cmdCode == CMD_WRITE_PAGE) | (cmdCode == CMD_ERASE_PAGE)) &
                    lockBits[regionOf(cmdPage)]) |
                   ((cmdCode == CMD_ERASE_ALL) & (|lockBits)); // R6

  // status and register read mux
  always_comb begin
    readMux = '0;
    case (paddr)
      REG_CTRL: readMux[CTRL_WS_BIT] = waitSel;
      REG_CMD: begin
        readMux[CMD_CODE_W-1:0] = cmdCode;
        readMux[CMD_PAGE_LSB +: PAGE_BITS] = cmdPage;
      end
      REG_STATUS: begin
        readMux[ST_READY] = readyFlag;
        readMux[ST_LOCKE] = lockError;
        readMux[ST_PROGRAMMING_ERROR_FLAG] = progError;
        readMux[ST_SECURE] = secure;
        readMux[ST_PAGE_AND_CHECK_RESULT] = qprResult;
        readMux[ST_FAST] = fastReadMode;
        readMux[ST_LOCK_LSB +: REGIONS] = lockBits;
      end
      REG_FUSE: readMux[FUSE_N-1:0] = fuses; // R17
      default: readMux = '0;
    endcase
  end

  // apb slave: one wait state, so every access completes in exactly three cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~apbMapped;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= readMux; // R8
      end
    end
  end

  // control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitSel <= 1'b0;
    end else if (apbFire & pwrite & (paddr == REG_CTRL)) begin
      waitSel <= pwdata[CTRL_WS_BIT]; // R5
    end
  end

  // command acceptance and status flags; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readyFlag <= 1'b1;
      progError <= 1'b0;
      lockError <= 1'b0;
      cmdPending <= 1'b0;
      cmdCode <= '0;
      cmdPage <= '0;
    end else begin
      progError <= (cmdWr & ~cmdOk) | (progError & ~statusRd); // R21 R22
      lockError <= (finish & finLockErr) | (lockError & ~statusRd);
      if (cmdStart) begin
        cmdPending <= 1'b0;
      end
      if (finish) begin
        readyFlag <= 1'b1; // R20
      end
      if (cmdWr & cmdOk) begin
        readyFlag <= 1'b0; // R20
        cmdPending <= 1'b1;
        cmdCode <= pwdata[CMD_CODE_W-1:0];
        cmdPage <= pwdata[CMD_PAGE_LSB +: PAGE_BITS];
      end
    end
  end

  // nonvolatile state changed by finished commands
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockBits <= '0;
      fuses <= '1;
      secure <= 1'b0;
      fastReadMode <= 1'b0; // R14
    end else if (finish & ~finLockErr) begin
      case (cmdCode)
        CMD_LOCK: lockBits[regionOf(cmdPage)] <= 1'b1; // R6
        CMD_UNLOCK: lockBits[regionOf(cmdPage)] <= 1'b0; // R6
        CMD_WRITE_FUSE: fuses[cmdPage[FUSE_IDX_W-1:0]] <= 1'b0; // R17
        CMD_ERASE_FUSE: fuses[cmdPage[FUSE_IDX_W-1:0]] <= 1'b1; // R17
        CMD_SET_SECURE: secure <= 1'b1; // R17
        CMD_ERASE_ALL: begin
          fuses <= '1;
          secure <= 1'b0; // R16
        end
        CMD_FAST_ON: fastReadMode <= 1'b1; // R13
        CMD_FAST_OFF: fastReadMode <= 1'b0; // R13
        default: fastReadMode <= fastReadMode;
      endcase
    end
  end

  // read path and command sequencer share one machine, so a command can only
  // start from idle and reads stall while the flash is busy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      rdPort <= '0;
      hready <= 1'b0;
      hrdata <= '0;
      pbufWe <= 1'b0;
      pbufIdx <= '0;
      pbufData <= '0;
      flashOp <= '0;
      volEraseReq <= 1'b0;
      curAddr <= '0;
      prefAddr <= '0;
      prefData <= '0;
      prefValid <= 1'b0;
      settleCnt <= '0;
      qIdx <= '0;
      qMode <= 1'b0;
      qAcc <= 1'b0;
      qprResult <= 1'b0;
      finish <= 1'b0;
      finLockErr <= 1'b0;
    end else begin
      rdPort[0].en <= 1'b0;
      rdPort[1].en <= 1'b0;
      hready <= 1'b0;
      pbufWe <= 1'b0;
      flashOp.valid <= 1'b0;
      finish <= 1'b0;
      finLockErr <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (busReq & hwrite) begin
            pbufWe <= 1'b1; // R7
            pbufIdx <= wAddr[WORD_IDX_W-1:0];
            pbufData <= hwdata;
            hready <= 1'b1;
            prefValid <= 1'b0;
          end else if (busReq & prefHit) begin
            hrdata <= prefData; // R4 R24
            hready <= 1'b1;
            prefValid <= 1'b0;
          end else if (busReq) begin
            curAddr <= wAddr;
            rdPort[wAddr[0]] <= '{en: 1'b1, addr: wAddr}; // R1 R3
            if (waitSel) begin
              rdPort[~wAddr[0]] <= '{en: 1'b1, addr: nextAddr}; // R2
            end
            state <= ST_ACCESS;
          end else if (cmdPending) begin
            prefValid <= 1'b0;
            if (lockHit) begin
              finish <= 1'b1;
              finLockErr <= 1'b1;
            end else begin
              case (cmdCode)
                CMD_ERASE_ALL: begin
                  volEraseReq <= 1'b1; // R16
                  state <= ST_VOL_ERASE;
                end
                CMD_WRITE_PAGE, CMD_ERASE_PAGE, CMD_CLEAR_PBUF,
                CMD_WRITE_USER, CMD_ERASE_USER: begin
                  flashOp <= '{valid: 1'b1, code: cmdCode, page: cmdPage}; // R11
                  state <= ST_CMD_RUN;
                end
                CMD_FAST_ON, CMD_FAST_OFF: begin
                  settleCnt <= 8'(HS_SETTLE_CYC); // R13
                  state <= ST_SETTLE;
                end
                CMD_PAGE_AND: begin
                  qIdx <= '0; // R15
                  qAcc <= 1'b1;
                  qMode <= 1'b1;
                  state <= ST_QISSUE;
                end
                default: finish <= 1'b1;
              endcase
            end
          end
        end
        ST_ACCESS: begin
          state <= waitSel ? ST_WAIT : ST_CAPTURE; // R5
        end
        ST_WAIT: begin
          state <= ST_CAPTURE;
        end
        ST_CAPTURE: begin
          state <= ST_IDLE;
          if (qMode) begin
            qAcc <= qAcc & (&rdData[curAddr[0]]); // R15
            if (qIdx == WORD_IDX_W'(-1)) begin
              qprResult <= qAcc & (&rdData[curAddr[0]]); // R15
              qMode <= 1'b0;
              finish <= 1'b1;
            end else begin
              qIdx <= qIdx + 1'b1;
              state <= ST_QISSUE;
            end
          end else begin
            hrdata <= rdData[curAddr[0]]; // R12
            hready <= 1'b1;
            if (waitSel) begin
              prefData <= rdData[~curAddr[0]]; // R2 R3
              prefAddr <= curAddr + 22'h00_0001;
              prefValid <= 1'b1;
            end
          end
        end
        ST_QISSUE: begin
          // one port per word keeps the check at zero wait power
          curAddr <= {1'b0, cmdPage, qIdx};
          rdPort[qIdx[0]] <= '{en: 1'b1, addr: {1'b0, cmdPage, qIdx}};
          state <= ST_ACCESS;
        end
        ST_VOL_ERASE: begin
          if (volEraseAck) begin
            volEraseReq <= 1'b0;
            flashOp <= '{valid: 1'b1, code: CMD_ERASE_ALL, page: '0}; // R11 R16
            state <= ST_CMD_RUN;
          end
        end
        ST_CMD_RUN: begin
          if (flashDone) begin
            finish <= 1'b1; // R20
            state <= ST_IDLE;
          end
        end
        ST_SETTLE: begin
          // extra wait states: reads queue behind the speed change
          if (settleCnt <= 8'h01) begin
            finish <= 1'b1; // R13
            state <= ST_IDLE;
          end else begin
            settleCnt <= settleCnt - 8'h01;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // power down only when no read or command could be in flight
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flashPowerDown <= 1'b0;
    end else begin
      flashPowerDown <= sleepReq & (state == ST_IDLE) & ~hvalid & ~cmdPending; // R18
    end
  end
endmodule : flash_ctrl

// [verif/flash_ctrl_monitor.sv]
// port checker for the flash controller
// assumes it is bound onto flash_ctrl and sees only its ports
`timescale 1ns/1ps
module flash_ctrl_monitor
  import flash_ctrl_pkg::*;
(
  // clock, reset and register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // fast port and flash side
  input wire logic hvalid,
  input wire logic [23:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire flash_ctrl_pkg::rd_port_s [1:0] rdPort,
  input wire logic pbufWe,
  input wire logic [flash_ctrl_pkg::WORD_IDX_W-1:0] pbufIdx,
  input wire logic [31:0] pbufData,
  input wire flash_ctrl_pkg::flash_op_s flashOp,
  input wire logic fastReadMode,
  input wire logic volEraseAck
);
  logic ws;
  logic volSeen;
  logic [6:0] wIdx;
  logic [3:0] hrGap;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign wIdx = haddr[8:2];
  // wait select mirrored from register writes, since latency depends on it
  always_ff @(posedge clk) begin
    if (!rst_n) ws <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == REG_CTRL) ws <= pwdata[0];
  end
  // cycles since the last fast port answer; the settle stall ends just before the mode flips
  always_ff @(posedge clk) begin
    if (!rst_n || hready) hrGap <= 4'h0;
    else if (hrGap != 4'hF) hrGap <= hrGap + 4'h1;
  end
  // volatile erase acknowledged since the last macro op
  always_ff @(posedge clk) begin
    if (!rst_n || flashOp.valid) volSeen <= 1'b0;
    else if (volEraseAck) volSeen <= 1'b1;
  end
  a_zero_wait_single: assert property (!ws |-> !(rdPort[0].en && rdPort[1].en))
    else $error("both read ports used in zero wait mode");
  a_one_wait_pair: assert property (ws && hvalid && !hready && (rdPort[0].en || rdPort[1].en)
    |-> rdPort[0].en && rdPort[1].en && (rdPort[0].addr == rdPort[1].addr + 22'd1
    || rdPort[1].addr == rdPort[0].addr + 22'd1)) else $error("one wait read not paired");
  a_port_parity: assert property (!(rdPort[0].en && rdPort[0].addr[0])
    && !(rdPort[1].en && !rdPort[1].addr[0])) else $error("word on wrong read port");
  a_miss_latency: assert property (ws && hvalid && !hready && rdPort[0].en && rdPort[1].en
    |-> !hready[*3] ##1 hready) else $error("one wait miss latency wrong");
  a_zero_latency: assert property (!ws && hvalid && !hready && (rdPort[0].en || rdPort[1].en)
    |-> !hready[*2] ##1 hready) else $error("zero wait latency wrong");
  a_apb_answer: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("register port answer late or early");
  a_pbuf_write: assert property (pbufWe |-> pbufData == $past(hwdata)
    && pbufIdx == $past(wIdx)) else $error("page buffer write wrong");
  a_erase_order: assert property (flashOp.valid && flashOp.code == CMD_ERASE_ALL |-> volSeen)
    else $error("flash erased before volatile memories");
  a_settle_stall: assert property ($changed(fastReadMode) |-> hrGap >= 4'd8)
    else $error("read answered during speed settle");
  c_hit: cover property (ws && hvalid && hready);
  c_erase_all: cover property (flashOp.valid && flashOp.code == CMD_ERASE_ALL);
  c_fast_on: cover property ($rose(fastReadMode));
endmodule : flash_ctrl_monitor

bind flash_ctrl flash_ctrl_monitor i_mon (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .hvalid, .haddr, .hwdata, .hready, .rdPort, .pbufWe, .pbufIdx, .pbufData,
  .flashOp, .fastReadMode, .volEraseAck);

// [verif/flash_model.sv]
// behavioural flash macro: two read ports, op completion, volatile erase ack
// assumes read data is sampled one or two cycles after the enable
`timescale 1ns/1ps
module flash_model
  import flash_ctrl_pkg::*;
#(
  parameter int DONE_CYC = 20
) (
  // clock
  input wire logic clk,
  // read ports
  input wire flash_ctrl_pkg::rd_port_s [1:0] rdPort,
  output logic [1:0][31:0] rdData,
  // operations
  input wire flash_ctrl_pkg::flash_op_s flashOp,
  output logic flashDone,
  output logic [5:0] lastCode,
  input wire logic volEraseReq,
  output logic volEraseAck
);
  int busyCnt = 0;
  initial begin
    rdData = '0;
    flashDone = 1'b0;
    lastCode = 6'h00;
    volEraseAck = 1'b0;
  end
  // page 3 reads all ones so a page AND result of one can be seen
  function automatic logic [31:0] word_at(input logic [21:0] a);
    return (a[20:7] == 14'h0003) ? 32'hFFFF_FFFF : {10'h155, a};
  endfunction : word_at
  // data lands the cycle after enable and holds until the next enable
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rdPort[i].en) rdData[i] <= word_at(rdPort[i].addr);
    end
  end
  // a macro op finishes after a fixed busy time, long enough to overlap a command
  always @(posedge clk) begin
    flashDone <= (busyCnt == 1);
    if (flashOp.valid) begin
      busyCnt <= DONE_CYC;
      lastCode <= flashOp.code;
    end else if (busyCnt != 0) busyCnt <= busyCnt - 1;
  end
  // one pulse per volatile erase request
  always @(posedge clk) volEraseAck <= volEraseReq && !volEraseAck;
endmodule : flash_model

// [verif/testbench.sv]
// self-checking bench for the dual-port flash read controller
// assumes the macro model beside the design and the bound port checker
`timescale 1ns/1ps
module testbench;
  import flash_ctrl_pkg::*;
  localparam logic [7:0] KEY = 8'hA5; // arbitrary key value
  // clock, reset and counters
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int errTotal = 0;
  int totalChecks = 0;
  // register port
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q, acc, last;
  logic pready, pslverr, e;
  // fast port
  logic hvalid = 1'b0;
  logic hwrite = 1'b0;
  logic [23:0] haddr = 24'h00_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic [31:0] hrdata;
  // flash side
  rd_port_s [1:0] rdPort;
  logic [1:0][31:0] rdData;
  logic [WORD_IDX_W-1:0] pbufIdx;
  logic [31:0] pbufData;
  flash_op_s flashOp;
  logic [5:0] lastCode;
  logic pbufWe, flashDone, fastReadMode, volEraseReq, volEraseAck, flashPowerDown;
  logic sleepReq = 1'b0;

  always #2 clk = ~clk;

  flash_ctrl #(.FUSE_N(32), .CMD_KEY(KEY)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hvalid(hvalid), .hwrite(hwrite), .haddr(haddr),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .rdPort(rdPort), .rdData(rdData),
    .pbufWe(pbufWe), .pbufIdx(pbufIdx), .pbufData(pbufData), .flashOp(flashOp),
    .flashDone(flashDone), .fastReadMode(fastReadMode), .volEraseReq(volEraseReq),
    .volEraseAck(volEraseAck), .sleepReq(sleepReq), .flashPowerDown(flashPowerDown));
  flash_model i_flash (.clk(clk), .rdPort(rdPort), .rdData(rdData), .flashOp(flashOp),
    .flashDone(flashDone), .lastCode(lastCode), .volEraseReq(volEraseReq),
    .volEraseAck(volEraseAck));

  task automatic endSim();
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : endSim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic timeout();
    errTotal++;
    $display("ERROR %0t: wait ran out", $time);
    endSim();
  endtask : timeout
  // one register transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 50);
    if (!pready) timeout();
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask : rdchk
  // fast port transfer; n counts edges from raising hvalid to the answer
  task automatic hx(input logic w, input logic [23:0] a, input logic [31:0] d, input int lat);
    int n = 0;
    @(posedge clk);
    hvalid <= 1'b1;
    hwrite <= w;
    haddr <= a;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (!hready && n < 200);
    if (!hready) timeout();
    hvalid <= 1'b0;
    chk(n, lat);
    if (!w) chk(hrdata, {10'h155, a[23:2]});
  endtask : hx
  // command write, then status polled until ready; acc keeps every flag seen
  task automatic cmd(input logic [7:0] k, input logic [5:0] c, input logic [13:0] pg);
    int n = 0;
    apb(1'b1, REG_CMD, {k, 2'b00, pg, 2'b00, c}, q, e);
    acc = 32'h0000_0000;
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000, last, e);
      acc = acc | last;
      n++;
    end while (!last[ST_READY] && n < 400);
    if (!last[ST_READY]) timeout();
  endtask : cmd

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(REG_STATUS, 32'h0000_0001);
    rdchk(REG_CTRL, 32'h0000_0000);
    rdchk(REG_FUSE, 32'hFFFF_FFFF);
    apb(1'b0, 8'h10, 32'h0000_0000, q, e);
    chk(e, 1'b1);
    $display("reset test done");
    hx(1'b0, 24'h00_0014, 32'h0000_0000, 4);
    hx(1'b0, 24'h80_0008, 32'h0000_0000, 4);
    hx(1'b1, 24'h00_0010, 32'h1234_5678, 2);
    $display("zero wait test done");
    apb(1'b1, REG_CTRL, 32'h0000_0001, q, e);
    rdchk(REG_CTRL, 32'h0000_0001);
    hx(1'b0, 24'h00_0020, 32'h0000_0000, 5);
    hx(1'b0, 24'h00_0024, 32'h0000_0000, 2);
    hx(1'b0, 24'h00_0030, 32'h0000_0000, 5);
    hx(1'b0, 24'h80_0000, 32'h0000_0000, 5);
    $display("one wait test done");
    cmd(8'h00, CMD_FAST_ON, 14'h0000);
    chk({acc[ST_PROGRAMMING_ERROR_FLAG], acc[ST_FAST]}, 2'b10);
    rdchk(REG_STATUS, 32'h0000_0001);
    cmd(KEY, 6'h3F, 14'h0000);
    chk(acc[ST_PROGRAMMING_ERROR_FLAG], 1'b1);
    cmd(KEY, CMD_FAST_ON, 14'h0000);
    chk({last[ST_FAST], fastReadMode}, 2'b11);
    hx(1'b0, 24'h00_0040, 32'h0000_0000, 5);
    apb(1'b1, REG_CMD, {KEY, 2'b00, 14'h0000, 2'b00, CMD_FAST_ON}, q, e);
    hx(1'b0, 24'h00_0050, 32'h0000_0000, 5 + HS_SETTLE_CYC);
    cmd(KEY, CMD_FAST_OFF, 14'h0000);
    chk({last[ST_FAST], fastReadMode}, 2'b00);
    $display("command test done");
    apb(1'b1, REG_CMD, {KEY, 2'b00, 14'h0000, 2'b00, CMD_ERASE_PAGE}, q, e);
    rdchk(REG_STATUS, 32'h0000_0000);
    cmd(KEY, CMD_CLEAR_PBUF, 14'h0000);
    chk({acc[ST_PROGRAMMING_ERROR_FLAG], last[ST_READY]}, 2'b11);
    chk(lastCode, CMD_ERASE_PAGE);
    cmd(KEY, CMD_PAGE_AND, 14'h0003);
    chk(last[ST_PAGE_AND_CHECK_RESULT], 1'b1);
    cmd(KEY, CMD_PAGE_AND, 14'h0000);
    chk(last[ST_PAGE_AND_CHECK_RESULT], 1'b0);
    cmd(KEY, CMD_ERASE_USER, 14'h0000);
    chk(lastCode, CMD_ERASE_USER);
    $display("busy and page check test done");
    cmd(KEY, CMD_LOCK, 14'h0000);
    chk(last[31:16], 16'h0001);
    cmd(KEY, CMD_ERASE_PAGE, 14'h0005);
    chk(acc[ST_LOCKE], 1'b1);
    cmd(KEY, CMD_ERASE_ALL, 14'h0000);
    chk(acc[ST_LOCKE], 1'b1);
    cmd(KEY, CMD_UNLOCK, 14'h0000);
    chk(last[31:16], 16'h0000);
    cmd(KEY, CMD_WRITE_FUSE, 14'h0002);
    rdchk(REG_FUSE, 32'hFFFF_FFFB);
    cmd(KEY, CMD_ERASE_FUSE, 14'h0002);
    cmd(KEY, CMD_WRITE_FUSE, 14'h0000);
    rdchk(REG_FUSE, 32'hFFFF_FFFE);
    cmd(KEY, CMD_SET_SECURE, 14'h0000);
    chk(last[ST_SECURE], 1'b1);
    cmd(KEY, CMD_ERASE_ALL, 14'h0000);
    chk({last[ST_SECURE], lastCode}, {1'b0, CMD_ERASE_ALL});
    rdchk(REG_FUSE, 32'hFFFF_FFFF);
    $display("lock and erase test done");
    sleepReq <= 1'b1;
    repeat (10) @(posedge clk);
    chk(flashPowerDown, 1'b1);
    sleepReq <= 1'b0;
    repeat (10) @(posedge clk);
    chk(flashPowerDown, 1'b0);
    $display("sleep test done");
    endSim();
  end
endmodule : testbench
